// file: logic/iaet_top.sv
// interrupt nodes, arbiter, transfer channels, external request router
//
// The strobed register port and the register offsets were decided locally.
module iaet_top (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  input  wire logic [7:0]                   reg_addr_i,
  input  wire logic [31:0]                  reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [31:0]                  reg_rdata_o,
  input  wire logic [iaet_pkg::NODES-1:0]   src_req_i,
  input  wire logic [iaet_pkg::SHARED_N-1:0] alt_src_i,
  input  wire logic [iaet_pkg::RTR_N-1:0]   ext_pin_i,
  input  wire logic                         trap_i,
  input  wire logic [3:0]                   trap_num_i,
  input  wire logic [iaet_pkg::PRIO_W-1:0]  cpu_prio_i,
  input  wire logic                         cpu_ack_i,
  output logic                              intr_req_o,
  output logic      [iaet_pkg::VEC_W-1:0]   intr_vec_o,
  output logic      [iaet_pkg::PRIO_W-1:0]  intr_prio_o,
  output logic                              intr_trap_o,
  output logic                              xfer_valid_o,
  output logic      [iaet_pkg::PTR_W-1:0]   xfer_src_o,
  output logic      [iaet_pkg::PTR_W-1:0]   xfer_dst_o,
  output logic                              xfer_word_o,
  output logic                              irq_o
);
  import iaet_pkg::*;

  // node state
  logic [NODES-1:0]  req_q;
  logic [NODES-1:0]  en_q;
  logic [NODES-1:0]  xm_q;
  logic [PRIO_W-1:0] prio_q [NODES];
  logic [2:0]        ch_q   [NODES];
  logic [NODES-1:0]  node_set;
  logic [NODES-1:0]  node_clr;
  logic [NODES-1:0]  node_wr;
  logic [NODES-1:0]  src_eff;

  // channel state
  logic [CNT_W-1:0]  cnt_q  [CHANS];
  logic [CHANS-1:0]  cont_q;
  logic [CHANS-1:0]  word_q;
  logic [CHANS-1:0]  incs_q;
  logic [CHANS-1:0]  incd_q;
  logic [PTR_W-1:0]  srcp_q [CHANS];
  logic [PTR_W-1:0]  dstp_q [CHANS];

  // router state
  logic [RTR_N-1:0]  pin_s1_q;
  logic [RTR_N-1:0]  pin_s2_q;
  logic [RTR_N-1:0]  pin_prev_q;
  logic [3:0]        rtr_in_q  [RTR_N];
  logic [5:0]        rtr_out_q [RTR_N];
  logic [RTR_N-1:0]  rtr_ev_q;
  logic [RTR_N-1:0]  rtr_ev_d;

  // misc registers
  logic [SHARED_N-1:0] sel_q;
  logic [STAT_W-1:0]   stat_q;
  logic [STAT_W-1:0]   mask_q;
  logic [STAT_W-1:0]   stat_set;
  logic                cache_q;
  iaet_state_t         state_q;
  logic [3:0]          wait_q;
  logic [6:0]          cur_q;
  logic                trap_pend_q;
  logic [3:0]          trap_num_q;

  // arbiter
  logic              found;
  logic [6:0]        best;
  logic [PRIO_W-1:0] best_prio;
  logic [2:0]        bch;
  logic              do_xfer;
  logic              xfer_fire;
  logic              last_xfer;

  logic wr_stat;
  assign wr_stat = reg_wr_i && reg_addr_i == A_STAT;

  // highest enabled pending above cpu level; lowest index breaks ties
  always_comb begin
    found     = 1'b0;
    best      = 7'h00;
    best_prio = '0;
    for (int n = 0; n < NODES; n++) begin
      if (req_q[n] && en_q[n] && prio_q[n] > cpu_prio_i && (!found || prio_q[n] > best_prio)) begin
        found     = 1'b1;
        best      = 7'(n);
        best_prio = prio_q[n];
      end
    end
  end

  assign bch       = ch_q[best];
  // exhausted non-continuous channel falls back to a vectored interrupt
  assign do_xfer   = xm_q[best] && (cont_q[bch] || cnt_q[bch] != '0);
  assign xfer_fire = state_q == ST_IDLE && !trap_pend_q && found && do_xfer;
  assign last_xfer = xfer_fire && !cont_q[bch] && cnt_q[bch] == 16'h0001;

  always_comb begin
    node_clr = '0;
    if (xfer_fire) begin
      node_clr[best] = 1'b1;
    end
    if (state_q == ST_PRES && cpu_ack_i && !intr_trap_o) begin
      node_clr[cur_q] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NODES; g++) begin : g_node
      if (g >= SHARED_BASE && g < SHARED_BASE + SHARED_N) begin : g_sh
        assign src_eff[g] = sel_q[g-SHARED_BASE] ? alt_src_i[g-SHARED_BASE] : src_req_i[g];
      end else if (g >= RTR_BASE && g < RTR_BASE + RTR_N) begin : g_rtr
        assign src_eff[g] = src_req_i[g] | rtr_ev_q[g-RTR_BASE];
      end else begin : g_ded
        assign src_eff[g] = src_req_i[g];
      end
      assign node_wr[g]  = reg_wr_i && reg_addr_i == 8'(g);
      // re-raise on the last transfer so the source vector follows
      assign node_set[g] = src_eff[g] || (last_xfer && best == 7'(g));

      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          req_q[g]  <= 1'b0;
          en_q[g]   <= 1'b0;
          xm_q[g]   <= 1'b0;
          prio_q[g] <= '0;
          ch_q[g]   <= '0;
        end else begin
          if (node_wr[g]) begin
            en_q[g]   <= reg_wdata_i[N_EN_BIT];
            xm_q[g]   <= reg_wdata_i[N_XFER_BIT];
            prio_q[g] <= reg_wdata_i[N_PRIO_LSB +: PRIO_W];
            ch_q[g]   <= reg_wdata_i[N_CH_LSB +: 3];
          end
          // hardware set wins over any clear
          if (node_set[g]) begin
            req_q[g] <= 1'b1;
          end else if (node_wr[g]) begin
            req_q[g] <= reg_wdata_i[N_REQ_BIT];
          end else if (node_clr[g]) begin
            req_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // channels: one transfer per service, at most one channel per cycle
  generate
    for (g = 0; g < CHANS; g++) begin : g_ch
      logic hit;
      assign hit = xfer_fire && bch == 3'(g);
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          cnt_q[g]  <= '0;
          cont_q[g] <= 1'b0;
          word_q[g] <= 1'b0;
          incs_q[g] <= 1'b0;
          incd_q[g] <= 1'b0;
          srcp_q[g] <= '0;
          dstp_q[g] <= '0;
        end else begin
          if (reg_wr_i && reg_addr_i == A_CHCTL + 8'(g)) begin
            cnt_q[g]  <= reg_wdata_i[CNT_W-1:0];
            cont_q[g] <= reg_wdata_i[C_CONT_BIT];
            word_q[g] <= reg_wdata_i[C_WORD_BIT];
            incs_q[g] <= reg_wdata_i[C_INCS_BIT];
            incd_q[g] <= reg_wdata_i[C_INCD_BIT];
          end else if (hit && !cont_q[g]) begin
            cnt_q[g] <= cnt_q[g] - 16'h0001;
          end
          if (reg_wr_i && reg_addr_i == A_SRCP + 8'(g)) begin
            srcp_q[g] <= reg_wdata_i[PTR_W-1:0];
          end else if (hit && incs_q[g]) begin
            srcp_q[g] <= srcp_q[g] + (word_q[g] ? 24'h00_0002 : 24'h00_0001);
          end
          if (reg_wr_i && reg_addr_i == A_DSTP + 8'(g)) begin
            dstp_q[g] <= reg_wdata_i[PTR_W-1:0];
          end else if (hit && incd_q[g]) begin
            dstp_q[g] <= dstp_q[g] + (word_q[g] ? 24'h00_0002 : 24'h00_0001);
          end
        end
      end
    end
  endgenerate

  // transfer strobe: one stolen cycle, never a vector
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      xfer_valid_o <= 1'b0;
      xfer_src_o   <= '0;
      xfer_dst_o   <= '0;
      xfer_word_o  <= 1'b0;
    end else begin
      xfer_valid_o <= xfer_fire;
      if (xfer_fire) begin
        xfer_src_o  <= srcp_q[bch];
        xfer_dst_o  <= dstp_q[bch];
        xfer_word_o <= word_q[bch];
      end
    end
  end

  // external pins cross into the core clock before edge detection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      pin_prev_q <= '0;
    end else begin
      pin_s1_q   <= ext_pin_i;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // trigger, matrix and gating
  always_comb begin
    logic [RTR_N-1:0] trig;
    logic [RTR_N-1:0] comb_ev;
    logic             match;
    trig    = '0;
    comb_ev = '0;
    match   = 1'b0;
    for (int i = 0; i < RTR_N; i++) begin
      trig[i] = (rtr_in_q[i][0] && pin_s2_q[i] && !pin_prev_q[i])
             || (rtr_in_q[i][1] && !pin_s2_q[i] && pin_prev_q[i]);
      if (trig[i]) begin
        comb_ev[rtr_in_q[i][3:2]] = 1'b1;
      end
    end
    for (int o = 0; o < RTR_N; o++) begin
      match = pin_s2_q == rtr_out_q[o][3:0];
      unique case (rtr_out_q[o][5:4])
        2'b00: rtr_ev_d[o] = 1'b0;
        2'b01: rtr_ev_d[o] = comb_ev[o];
        2'b10: rtr_ev_d[o] = comb_ev[o] && match;
        2'b11: rtr_ev_d[o] = comb_ev[o] && !match;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rtr_ev_q <= '0;
    end else begin
      rtr_ev_q <= rtr_ev_d;
    end
  end

  // presentation sequencer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      wait_q      <= '0;
      cur_q       <= '0;
      intr_req_o  <= 1'b0;
      intr_vec_o  <= '0;
      intr_prio_o <= '0;
      intr_trap_o <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (trap_pend_q) begin
            state_q     <= ST_PRES;
            intr_req_o  <= 1'b1;
            intr_trap_o <= 1'b1;
            intr_vec_o  <= TRAP_VEC_BASE + 7'(trap_num_q);
            intr_prio_o <= '1;
          end else if (found && !do_xfer) begin
            state_q <= ST_WAIT;
            cur_q   <= best;
            wait_q  <= cache_q ? RESP_CACHE_CNT : RESP_NOCACHE_CNT;
          end
        end
        ST_WAIT: begin
          if (trap_pend_q) begin
            // trap preempts; the node keeps its flag and is re-arbitrated
            state_q     <= ST_PRES;
            intr_req_o  <= 1'b1;
            intr_trap_o <= 1'b1;
            intr_vec_o  <= TRAP_VEC_BASE + 7'(trap_num_q);
            intr_prio_o <= '1;
          end else if (trap_i) begin
            // hold the countdown so a trap arriving now is never overtaken
            state_q <= ST_WAIT;
          end else if (wait_q == 4'h0) begin
            state_q     <= ST_PRES;
            intr_req_o  <= 1'b1;
            intr_vec_o  <= cur_q;
            intr_prio_o <= prio_q[cur_q];
          end else begin
            wait_q <= wait_q - 4'h1;
          end
        end
        ST_PRES: begin
          if (cpu_ack_i) begin
            state_q     <= ST_IDLE;
            intr_req_o  <= 1'b0;
            intr_trap_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // trap capture; a new trap on the ack cycle is kept
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      trap_pend_q <= 1'b0;
      trap_num_q  <= '0;
    end else if (trap_i) begin
      trap_pend_q <= 1'b1;
      trap_num_q  <= trap_num_i;
    end else if (trap_pend_q && state_q != ST_PRES) begin
      trap_pend_q <= 1'b0;
    end
  end

  // status events, set wins over write-one-clear
  always_comb begin
    stat_set                          = '0;
    stat_set[bch]                     = last_xfer;
    stat_set[S_TRAP_BIT]              = trap_i;
    stat_set[S_RTR_LSB +: RTR_N]      = rtr_ev_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stat_q  <= '0;
      mask_q  <= '0;
      sel_q   <= '0;
      cache_q <= 1'b1;
      irq_o   <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? reg_wdata_i[STAT_W-1:0] : '0)) | stat_set;
      irq_o  <= |(stat_q & mask_q);
      if (reg_wr_i && reg_addr_i == A_MASK) begin
        mask_q <= reg_wdata_i[STAT_W-1:0];
      end
      if (reg_wr_i && reg_addr_i == A_SEL) begin
        sel_q <= reg_wdata_i[SHARED_N-1:0];
      end
      if (reg_wr_i && reg_addr_i == A_CFG) begin
        cache_q <= reg_wdata_i[0];
      end
    end
  end

  generate
    for (g = 0; g < RTR_N; g++) begin : g_rtrcfg
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          rtr_in_q[g]  <= '0;
          rtr_out_q[g] <= '0;
        end else begin
          if (reg_wr_i && reg_addr_i == A_RTRIN + 8'(g)) begin
            rtr_in_q[g] <= reg_wdata_i[3:0];
          end
          if (reg_wr_i && reg_addr_i == A_RTROUT + 8'(g)) begin
            rtr_out_q[g] <= reg_wdata_i[5:0];
          end
        end
      end
    end
  endgenerate

  // read port; unmapped words read zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      if (reg_addr_i < A_CHCTL) begin
        reg_rdata_o[9:0] <= {ch_q[reg_addr_i[6:0]], xm_q[reg_addr_i[6:0]], req_q[reg_addr_i[6:0]],
                             en_q[reg_addr_i[6:0]], prio_q[reg_addr_i[6:0]]};
      end else if (reg_addr_i < A_SRCP) begin
        reg_rdata_o[19:0] <= {incd_q[reg_addr_i[2:0]], incs_q[reg_addr_i[2:0]], word_q[reg_addr_i[2:0]],
                              cont_q[reg_addr_i[2:0]], cnt_q[reg_addr_i[2:0]]};
      end else if (reg_addr_i < A_DSTP) begin
        reg_rdata_o[PTR_W-1:0] <= srcp_q[reg_addr_i[2:0]];
      end else if (reg_addr_i < A_SEL) begin
        reg_rdata_o[PTR_W-1:0] <= dstp_q[reg_addr_i[2:0]];
      end else if (reg_addr_i == A_SEL) begin
        reg_rdata_o[SHARED_N-1:0] <= sel_q;
      end else if (reg_addr_i >= A_RTRIN && reg_addr_i < A_RTROUT) begin
        reg_rdata_o[3:0] <= rtr_in_q[reg_addr_i[1:0]];
      end else if (reg_addr_i >= A_RTROUT && reg_addr_i < A_STAT) begin
        reg_rdata_o[5:0] <= rtr_out_q[reg_addr_i[1:0]];
      end else if (reg_addr_i == A_STAT) begin
        reg_rdata_o[STAT_W-1:0] <= stat_q;
      end else if (reg_addr_i == A_MASK) begin
        reg_rdata_o[STAT_W-1:0] <= mask_q;
      end else if (reg_addr_i == A_CFG) begin
        reg_rdata_o[0] <= cache_q;
      end else if (reg_addr_i == A_STATE) begin
        reg_rdata_o[14:0] <= {pin_s2_q, cur_q, 1'b0, state_q};
      end
    end
  end
endmodule : iaet_top

// file: logic/iaet_pkg.sv
// constants and register map of the interrupt and event transfer block
// Function
// - each request: vectored interrupt or transfer channel
// - interrupt service branches to request's vector
// - transfer steals exactly one cycle, no branch
// - move byte/word, increment source/destination pointers
// - counter decrements per service unless continuous
// - counter reaching zero raises source's interrupt
// - eight independent request-triggered transfer channels
// - response 7 clocks with jump cache, else 11
// - 96 nodes: request, enable, priority each
// - shared nodes pick source by select register
// - router: 4 inputs, matrix, 4 gating stages
// - input trigger: rising, falling or both edges
// - gating stage passes events on pattern match/miss
// - hardware trap branches immediately like interrupt
// - priority field gives 16 levels
// - channel pointers are 24 bits wide
package iaet_pkg;
  localparam int NODES       = 96;
  localparam int CHANS       = 8;
  localparam int RTR_N       = 4;
  localparam int PRIO_W      = 4;
  localparam int PTR_W       = 24;
  localparam int CNT_W       = 16;
  localparam int SHARED_N    = 8;
  localparam int SHARED_BASE = 88;
  localparam int RTR_BASE    = 84;
  localparam int STAT_W      = 13;
  localparam int VEC_W       = 7;
  // word-indexed register map
  localparam logic [7:0] A_NODE   = 8'h00;
  localparam logic [7:0] A_CHCTL  = 8'h60;
  localparam logic [7:0] A_SRCP   = 8'h68;
  localparam logic [7:0] A_DSTP   = 8'h70;
  localparam logic [7:0] A_SEL    = 8'h78;
  localparam logic [7:0] A_RTRIN  = 8'h80;
  localparam logic [7:0] A_RTROUT = 8'h84;
  localparam logic [7:0] A_STAT   = 8'h88;
  localparam logic [7:0] A_MASK   = 8'h89;
  localparam logic [7:0] A_CFG    = 8'h8A;
  localparam logic [7:0] A_STATE  = 8'h8B;
  // node control fields
  localparam int N_PRIO_LSB = 0;
  localparam int N_EN_BIT   = 4;
  localparam int N_REQ_BIT  = 5;
  localparam int N_XFER_BIT = 6;
  localparam int N_CH_LSB   = 7;
  // channel control fields
  localparam int C_CONT_BIT = 16;
  localparam int C_WORD_BIT = 17;
  localparam int C_INCS_BIT = 18;
  localparam int C_INCD_BIT = 19;
  // status layout
  localparam int S_TRAP_BIT = 8;
  localparam int S_RTR_LSB  = 9;
  // response latency in CPU clocks
  localparam int RESP_CACHE   = 7;
  localparam int RESP_NOCACHE = 11;
  localparam logic [3:0] RESP_CACHE_CNT   = 4'(RESP_CACHE - 2);
  localparam logic [3:0] RESP_NOCACHE_CNT = 4'(RESP_NOCACHE - 2);
  localparam logic [VEC_W-1:0] TRAP_VEC_BASE = 7'h60;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_PRES = 3'b100
  } iaet_state_t;
endpackage : iaet_pkg

// file: bench/iaet_asserts.sv
// concurrent checks on the interrupt and transfer ports of the block
module iaet_asserts
  import iaet_pkg::*;
(
  input wire logic                          core_clk_i,
  input wire logic                          rst_i,
  input wire logic                          trap_i,
  input wire logic [3:0]                    trap_num_i,
  input wire logic [iaet_pkg::PRIO_W-1:0]   cpu_prio_i,
  input wire logic                          cpu_ack_i,
  input wire logic                          intr_req_o,
  input wire logic [iaet_pkg::VEC_W-1:0]    intr_vec_o,
  input wire logic [iaet_pkg::PRIO_W-1:0]   intr_prio_o,
  input wire logic                          intr_trap_o,
  input wire logic                          xfer_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_drops_req: assert property (
    intr_req_o && cpu_ack_i |=> !intr_req_o)
    else $error("request still up after acknowledge");
  a_req_holds: assert property (
    intr_req_o && !cpu_ack_i |=> intr_req_o && $stable(intr_vec_o))
    else $error("presented request changed before acknowledge");
  a_trap_resp: assert property (
    trap_i && !intr_req_o |-> ##2 intr_req_o && intr_trap_o
      && intr_vec_o == TRAP_VEC_BASE + {3'b000, $past(trap_num_i, 2)})
    else $error("trap not presented two cycles later");
  a_trap_prio: assert property (
    intr_trap_o |-> intr_req_o && intr_prio_o == 4'hf)
    else $error("trap presented without top priority");
  a_prio_above: assert property (
    $rose(intr_req_o) && !intr_trap_o |-> intr_prio_o > cpu_prio_i)
    else $error("request presented at or below cpu level");
  a_resp_min: assert property (
    intr_req_o && cpu_ack_i |=> (!intr_req_o || intr_trap_o) [*7])
    else $error("next interrupt faster than minimum response");
  a_xfer_nobranch: assert property (
    xfer_valid_o |-> !intr_req_o)
    else $error("transfer cycle together with a branch");
  a_vec_range: assert property (
    intr_req_o && !intr_trap_o |-> intr_vec_o < 7'h60)
    else $error("node vector beyond the node range");
endmodule : iaet_asserts

// file: bench/iaet_cpu_model.sv
// behavioural cpu core that accepts presented interrupts
module iaet_cpu_model
  import iaet_pkg::*;
(
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        intr_req_i,
  input  wire logic [iaet_pkg::VEC_W-1:0]  intr_vec_i,
  input  wire logic [3:0]                  ack_dly_i,
  output logic                             ack_o,
  output logic      [iaet_pkg::VEC_W-1:0]  last_vec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // one pulse per presentation, so a slow core never acks twice
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_o      <= 1'b0;
      wait_q     <= 4'h0;
      last_vec_o <= '0;
    end else if (ack_o) begin
      ack_o  <= 1'b0;
      wait_q <= 4'h0;
    end else if (intr_req_i) begin
      if (wait_q >= ack_dly_i) begin
        ack_o      <= 1'b1;
        last_vec_o <= intr_vec_i;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : iaet_cpu_model

// file: bench/tb.sv
// self-checking bench for the interrupt and event transfer block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iaet_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, trap = 1'b0;
  logic [7:0]  addr = 8'h00, alt = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [95:0] src = '0;
  logic [3:0]  pin = 4'h0, tnum = 4'h0, prio = 4'h0, dly = 4'h0, iprio;
  logic        ireq, itrap, xv, xw, irq, ack;
  logic [6:0]  vec, lvec;
  logic [23:0] xs, xd;
  int          err_total = 0, tests_run = 0, cyc = 0, n = 0;

  iaet_top dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .src_req_i(src), .alt_src_i(alt), .ext_pin_i(pin), .trap_i(trap),
    .trap_num_i(tnum), .cpu_prio_i(prio), .cpu_ack_i(ack), .intr_req_o(ireq), .intr_vec_o(vec),
    .intr_prio_o(iprio), .intr_trap_o(itrap), .xfer_valid_o(xv), .xfer_src_o(xs), .xfer_dst_o(xd),
    .xfer_word_o(xw), .irq_o(irq));
  iaet_cpu_model cpu (.core_clk_i(clk), .rst_i(rst), .intr_req_i(ireq), .intr_vec_i(vec),
    .ack_dly_i(dly), .ack_o(ack), .last_vec_o(lvec));

  initial forever #2.5 clk = ~clk;
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  function automatic logic [95:0] bn(input int i);
    return 96'(1) << i;
  endfunction : bn
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rchk
  task automatic kick(input logic [95:0] s, input logic [7:0] a, input logic t);
    @(posedge clk);
    src <= s;
    alt <= a;
    trap <= t;
    @(posedge clk);
    src <= '0;
    alt <= '0;
    trap <= 1'b0;
    #1 n = 1;
  endtask : kick
  task automatic wait_req();
    while (ireq !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_req
  task automatic wait_idle();
    n = 0;
    while (ireq !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk(32'(ireq), 0);
    n = 1;
  endtask : wait_idle
  // en of zero skips the latency figure
  task automatic served(input logic [31:0] en, input logic [31:0] v, input logic [31:0] p);
    wait_req();
    if (en != 0) chk(32'(n), en);
    chk(32'(vec), v);
    chk(32'(iprio), p);
    wait_idle();
  endtask : served
  task automatic xchk(input logic [23:0] s, input logic [23:0] d, input logic w);
    while (xv !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk(32'(n), 2);
    chk(32'(xs), 32'(s));
    chk(32'(xd), 32'(d));
    chk(32'(xw), 32'(w));
  endtask : xchk
  task automatic edge_chk(input logic lvl, input logic hit);
    @(posedge clk);
    pin[0] <= lvl;
    repeat (8) @(posedge clk);
    rchk(A_STAT, hit ? 32'h0000_0200 : 32'h0000_0000);
    wreg(A_STAT, 32'h0000_1E00);
  endtask : edge_chk

  task automatic t_regs();
    rchk(A_CFG, 32'h0000_0001);
    wreg(A_NODE + 8'h07, 32'h0000_001F);
    rchk(A_NODE + 8'h07, 32'h0000_001F);
    rchk(8'hFF, 32'h0000_0000);
  endtask : t_regs
  task automatic t_latency();
    wreg(A_NODE + 8'h05, 32'h0000_0013);
    kick(bn(5), 8'h00, 1'b0);
    served(8, 5, 3);
    rchk(A_NODE + 8'h05, 32'h0000_0013);
    wreg(A_CFG, 32'h0000_0000);
    kick(bn(5), 8'h00, 1'b0);
    served(12, 5, 3);
    wreg(A_CFG, 32'h0000_0001);
  endtask : t_latency
  task automatic t_prio();
    dly = 4'h5;
    wreg(A_NODE + 8'h0A, 32'h0000_0012);
    wreg(A_NODE + 8'h14, 32'h0000_0016);
    kick(bn(10) | bn(20), 8'h00, 1'b0);
    served(8, 20, 6);
    served(8, 10, 2);
    chk(32'(lvec), 10);
    dly = 4'h0;
    @(posedge clk);
    prio <= 4'h6;
    wreg(A_NODE + 8'h1E, 32'h0000_0015);
    kick(bn(30), 8'h00, 1'b0);
    wait_req();
    chk(32'(ireq), 0);
    @(posedge clk);
    prio <= 4'h0;
    n = 1;
    served(0, 30, 5);
  endtask : t_prio
  task automatic t_xfer();
    wreg(A_CHCTL + 8'h01, 32'h000E_0002);
    wreg(A_SRCP + 8'h01, 32'h0010_0000);
    wreg(A_DSTP + 8'h01, 32'h0020_0000);
    wreg(A_NODE + 8'h28, 32'h0000_00D4);
    kick(bn(40), 8'h00, 1'b0);
    xchk(24'h10_0000, 24'h20_0000, 1'b1);
    kick(bn(40), 8'h00, 1'b0);
    xchk(24'h10_0002, 24'h20_0002, 1'b1);
    served(0, 40, 4);
    rchk(A_STAT, 32'h0000_0002);
    rchk(A_CHCTL + 8'h01, 32'h000E_0000);
    wreg(A_STAT, 32'h0000_0002);
    wreg(A_CHCTL + 8'h02, 32'h0005_0000);
    wreg(A_SRCP + 8'h02, 32'h0030_0000);
    wreg(A_DSTP + 8'h02, 32'h0040_0000);
    wreg(A_NODE + 8'h29, 32'h0000_0154);
    kick(bn(41), 8'h00, 1'b0);
    xchk(24'h30_0000, 24'h40_0000, 1'b0);
    kick(bn(41), 8'h00, 1'b0);
    xchk(24'h30_0001, 24'h40_0000, 1'b0);
    wait_req();
    chk(32'(ireq), 0);
    rchk(A_CHCTL + 8'h02, 32'h0005_0000);
  endtask : t_xfer
  task automatic t_shared();
    wreg(A_SEL, 32'h0000_0001);
    wreg(A_NODE + 8'h58, 32'h0000_0011);
    kick(bn(88), 8'h00, 1'b0);
    wait_req();
    chk(32'(ireq), 0);
    kick('0, 8'h01, 1'b0);
    served(8, 88, 1);
  endtask : t_shared
  task automatic t_trap();
    @(posedge clk);
    tnum <= 4'h3;
    kick('0, 8'h00, 1'b1);
    wait_req();
    chk(32'(itrap), 32'h0000_0001);
    served(2, 7'h63, 4'hF);
    rchk(A_STAT, 32'h0000_0100);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 0);
    wreg(A_MASK, 32'h0000_0100);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 1);
    wreg(A_STAT, 32'h0000_0100);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 0);
  endtask : t_trap
  task automatic t_router();
    wreg(A_RTROUT, 32'h0000_0010);
    for (int m = 1; m < 4; m++) begin
      wreg(A_RTRIN, 32'(m));
      edge_chk(1'b1, m[0]);
      edge_chk(1'b0, m[1]);
    end
    wreg(A_RTROUT, 32'h0000_0000);
    edge_chk(1'b1, 1'b0);
    wreg(A_RTROUT, 32'h0000_0021);
    edge_chk(1'b0, 1'b0);
    edge_chk(1'b1, 1'b1);
    wreg(A_RTROUT, 32'h0000_0031);
    edge_chk(1'b0, 1'b1);
    edge_chk(1'b1, 1'b0);
  endtask : t_router

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_latency();
    t_prio();
    t_xfer();
    t_shared();
    t_trap();
    t_router();
    results();
  end
endmodule : tb

bind iaet_top iaet_asserts u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .trap_i(trap_i),
  .trap_num_i(trap_num_i), .cpu_prio_i(cpu_prio_i), .cpu_ack_i(cpu_ack_i), .intr_req_o(intr_req_o),
  .intr_vec_o(intr_vec_o), .intr_prio_o(intr_prio_o), .intr_trap_o(intr_trap_o), .xfer_valid_o(xfer_valid_o));
